// *** rtl/serial_pin_cfg.svh ***
// Constants for the serial pin output mode, interrupt and signal detect block
`ifndef SERIAL_PIN_CFG_SVH
`define SERIAL_PIN_CFG_SVH

`define NUM_PINS            128
`define NUM_PORTS           32
`define NUM_MODULES         65
`define NUM_SERDES          32
`define NUM_PWM             3

`define CLK_MHZ             250
`define BLINK_HALF_US       25000
`define ENV_TICK_US         1000
`define ENV_TICK_MS         1
`define ENV_STRETCH_MS      100
`define ENV_STRETCH_TICKS   (`ENV_STRETCH_MS / `ENV_TICK_MS)
`define BLINK_TICK_CYCLES   (`BLINK_HALF_US * `CLK_MHZ)
`define ENV_TICK_CYCLES     (`ENV_TICK_US * `CLK_MHZ)

`define OFS_CFG             12'h000
`define OFS_SD_CFG          12'h004
`define OFS_PWM_DUTY        12'h008
`define BANK_POLARITY       8'h01
`define BANK_RAW            8'h02
`define BANK_TRIG_LOW       8'h03
`define BANK_TRIG_HIGH      8'h04
`define BANK_STICKY         8'h05
`define BANK_ENABLE         8'h06
`define BANK_ACTIVE         8'h07
`define BANK_INPUT          8'h08
`define REGION_PIN_CFG      3'h1
`define REGION_PORT_MAP     3'h2
`define REGION_SERDES_MAP   3'h3

`define CFG_RATE_A_LSB      0
`define CFG_RATE_B_LSB      2
`define CFG_RESTART_BIT     4
`define SD_HIGH_MAP_BIT     0
`define SD_CUSTOM_MAP_BIT   1

`define CTRL2_SPLIT_PORT    5'h10
`define CTRL2_PORT0_MODULE  7'h40

`endif

// *** rtl/serial_pin_pkg.sv ***
// Types for the serial pin output mode, interrupt and signal detect block
`include "serial_pin_cfg.svh"

package serial_pin_pkg;

  typedef enum logic [2:0] {
    SRC_STATIC_LOW  = 3'h0,
    SRC_STATIC_HIGH = 3'h1,
    SRC_BLINK_A     = 3'h2,
    SRC_BLINK_B     = 3'h3,
    SRC_ACT_A       = 3'h4,
    SRC_ACT_B       = 3'h5,
    SRC_ACT_A_INV   = 3'h6,
    SRC_ACT_B_INV   = 3'h7
  } bit_source_t;

  typedef enum logic [1:0] {
    TRIG_LEVEL   = 2'h0,
    TRIG_ANY     = 2'h1,
    TRIG_FALLING = 2'h2,
    TRIG_RISING  = 2'h3
  } trigger_t;

  typedef struct packed {
    logic        invert;
    logic [1:0]  pwm_sel;
    bit_source_t source;
  } pin_cfg_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic [1:0]                          blink_gen_a_rate;
    logic [1:0]                          blink_gen_b_rate;
    logic                                signal_detect_high_map;
    logic                                signal_detect_custom_map_on;
    logic [`NUM_PWM-1:0][7:0]            pwm_duty;
    logic [`NUM_PINS-1:0]                input_polarity_vector;
    logic [`NUM_PINS-1:0]                irq_trigger_low_bits;
    logic [`NUM_PINS-1:0]                irq_trigger_high_bits;
    logic [`NUM_PINS-1:0]                irq_sticky_vector;
    logic [`NUM_PINS-1:0]                irq_enable_vector;
    logic [`NUM_PINS-1:0]                prev_raw;
    logic [`NUM_PINS-1:0]                sampled;
    logic [1:0]                          bursts_seen;
    pin_cfg_t [`NUM_PINS-1:0]            pin_cfg;
    logic [`NUM_MODULES-1:0][6:0]        port_detect_map_table;
    logic [`NUM_SERDES-1:0][6:0]         serdes_detect_map_table;
    logic [22:0]                         blink_pre;
    logic [3:0]                          blink_cnt;
    logic                                burst_tgl;
    logic [17:0]                         env_pre;
    logic [`NUM_PORTS-1:0][7:0]          env_cnt;
    logic [`NUM_MODULES-1:0]             act_s1;
    logic [`NUM_MODULES-1:0]             act_s2;
    logic [`NUM_MODULES-1:0]             act_s3;
    logic [7:0]                          pwm_cnt;
    logic [`NUM_PINS-1:0]                pin_out;
    logic [`NUM_MODULES-1:0]             port_detect;
    logic [`NUM_SERDES-1:0]              serdes_detect;
    logic                                irq;
    logic [31:0]                         rdata;
  } state_t;

endpackage

// *** rtl/serial_pin_modes.sv ***
// Serial pin output modes, input interrupts and signal detect forwarding
// Function
// - Each pin picks static level, blink generator or link-activity blinking.
// - Per-pin PWM source and polarity inversion modify the chosen output.
// - Static mode drives a constant software-chosen 0 or 1 each burst.
// - Two blink generators; each blinking pin selects one of them.
// - Generator A rate code 0..3 gives 20, 10, 5, 2.5 Hz.
// - Generator B codes 0..2 give 20, 10, 5 Hz; 3 toggles per burst.
// - Restart control resets blink counters; software restarts all controllers together.
// - Activity mode gates blink with envelope; source code picks envelope polarity.
// - Activity pulse stretches envelope to 100 ms; more pulses add 100 ms, saturating at 255 ms.
// - Envelope driven by activity from the port module mapped to the port.
// - Controller 0: n; controller 1: 32+n; controller 2: 64, n, 32+n.
// - One bit per input for 128 inputs; per-bit enable gates interrupts.
// - Raw bit follows polarity-corrected sampled input continuously.
// - Sticky bit sets on level, any edge, falling or rising trigger.
// - Sticky bits cleared only by software writing 1; 0 leaves unchanged.
// - Active vector equals sticky AND enable, updating with either.
// - One level interrupt output, high while any active bit is set.
// - Bit 0 of each port forwards to the signal detect of the port module mapped to that port.
// - High-map select picks low or high module where two can map.
// - Custom map select routes any input through two mapping tables.
// - Parallel GPIO signal detect overrides serial value for that module.
// - Same polarity setting applies to interrupts and signal detect.
// - Inputs update once per burst; second burst brings the first values.
`timescale 1ns/100ps
`default_nettype none
`include "serial_pin_cfg.svh"

module serial_pin_modes
  import serial_pin_pkg::*;
#(
  parameter int CTRL_INDEX        = 0,
  parameter int BLINK_TICK_CYCLES = `BLINK_TICK_CYCLES,
  parameter int ENV_TICK_CYCLES   = `ENV_TICK_CYCLES
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire reg_req_t                reg_req_in,
  output logic [31:0]                  rdata_out,
  input  wire logic                    burst_done_in,
  input  wire logic [`NUM_PINS-1:0]    serial_in_data_in,
  input  wire logic [`NUM_MODULES-1:0] port_activity_in,
  input  wire logic [`NUM_MODULES-1:0] parallel_detect_sel_in,
  input  wire logic [`NUM_MODULES-1:0] parallel_detect_val_in,
  output logic [`NUM_PINS-1:0]         pin_out_data_out,
  output logic [`NUM_MODULES-1:0]      port_detect_out,
  output logic [`NUM_SERDES-1:0]       serdes_detect_out,
  output logic                         irq_out
);

  // Activity module feeding a serial port's envelope
  function automatic logic [6:0] act_module(input int ctrl, input logic [4:0] port);
    logic [6:0] m;
    m = {2'b00, port};
    case (ctrl)
      0: m = {2'b00, port};
      1: m = {2'b01, port};
      default: begin
        if (port == 5'h00) begin
          m = `CTRL2_PORT0_MODULE;
        end else if (port < `CTRL2_SPLIT_PORT) begin
          m = {2'b00, port};
        end else begin
          m = {2'b01, port};
        end
      end
    endcase
    return m;
  endfunction

  function automatic logic [31:0] word_of(input logic [`NUM_PINS-1:0] v, input logic [1:0] w);
    return v[w*32 +: 32];
  endfunction

  function automatic logic [`NUM_PINS-1:0] put_word(input logic [`NUM_PINS-1:0] v,
                                                    input logic [1:0]  w,
                                                    input logic [31:0] d);
    logic [`NUM_PINS-1:0] r;
    r = v;
    r[w*32 +: 32] = d;
    return r;
  endfunction

  state_t s_reg;
  state_t s_next;

  logic [`NUM_PINS-1:0] raw;
  logic [`NUM_PINS-1:0] active;

  assign raw    = s_reg.sampled ^ s_reg.input_polarity_vector;
  assign active = s_reg.irq_sticky_vector & s_reg.irq_enable_vector;

  always_comb begin
    logic                   wr_hit;
    logic                   blink_tick;
    logic                   env_tick;
    logic                   blink_a;
    logic                   blink_b;
    logic                   pat;
    logic                   env_on;
    logic                   gate;
    logic [1:0]             word;
    logic [7:0]             bank;
    logic [6:0]             idx;
    logic [6:0]             mod;
    logic [8:0]             sum;
    logic [4:0]             port;
    logic [`NUM_PINS-1:0]   clr;
    logic [`NUM_PINS-1:0]   set;
    logic [`NUM_MODULES-1:0] act_pulse;
    logic [`NUM_MODULES-1:0] det;
    logic [31:0]            rd_val;
    pin_cfg_t               pc;
    trigger_t               trig;
    wr_hit     = 1'b0;
    blink_tick = 1'b0;
    env_tick   = 1'b0;
    blink_a    = 1'b0;
    blink_b    = 1'b0;
    pat        = 1'b0;
    env_on     = 1'b0;
    gate       = 1'b1;
    word       = reg_req_in.addr[3:2];
    bank       = reg_req_in.addr[11:4];
    idx        = reg_req_in.addr[8:2];
    mod        = 7'h00;
    sum        = 9'h000;
    port       = 5'h00;
    clr        = '0;
    set        = '0;
    act_pulse  = '0;
    det        = '0;
    rd_val     = 32'h0000_0000;
    pc         = '0;
    trig       = TRIG_LEVEL;
    s_next     = s_reg;

    // Register writes
    wr_hit = reg_req_in.wr;
    if (wr_hit) begin
      if (reg_req_in.addr == `OFS_CFG) begin
        s_next.blink_gen_a_rate = reg_req_in.wdata[`CFG_RATE_A_LSB +: 2];
        s_next.blink_gen_b_rate = reg_req_in.wdata[`CFG_RATE_B_LSB +: 2];
      end else if (reg_req_in.addr == `OFS_SD_CFG) begin
        s_next.signal_detect_high_map      = reg_req_in.wdata[`SD_HIGH_MAP_BIT];
        s_next.signal_detect_custom_map_on = reg_req_in.wdata[`SD_CUSTOM_MAP_BIT];
      end else if (reg_req_in.addr == `OFS_PWM_DUTY) begin
        s_next.pwm_duty = reg_req_in.wdata[`NUM_PWM*8-1:0];
      end else if (bank == `BANK_POLARITY) begin
        s_next.input_polarity_vector =
          put_word(s_reg.input_polarity_vector, word, reg_req_in.wdata);
      end else if (bank == `BANK_TRIG_LOW) begin
        s_next.irq_trigger_low_bits =
          put_word(s_reg.irq_trigger_low_bits, word, reg_req_in.wdata);
      end else if (bank == `BANK_TRIG_HIGH) begin
        s_next.irq_trigger_high_bits =
          put_word(s_reg.irq_trigger_high_bits, word, reg_req_in.wdata);
      end else if (bank == `BANK_STICKY) begin
        clr = put_word('0, word, reg_req_in.wdata);
      end else if (bank == `BANK_ENABLE) begin
        s_next.irq_enable_vector =
          put_word(s_reg.irq_enable_vector, word, reg_req_in.wdata);
      end else if (reg_req_in.addr[11:9] == `REGION_PIN_CFG) begin
        s_next.pin_cfg[idx] = pin_cfg_t'(reg_req_in.wdata[5:0]);
      end else if (reg_req_in.addr[11:9] == `REGION_PORT_MAP) begin
        if (idx < 7'(`NUM_MODULES)) begin
          s_next.port_detect_map_table[idx] = reg_req_in.wdata[6:0];
        end
      end else if (reg_req_in.addr[11:9] == `REGION_SERDES_MAP) begin
        if (idx < 7'(`NUM_SERDES)) begin
          s_next.serdes_detect_map_table[idx[4:0]] = reg_req_in.wdata[6:0];
        end
      end
    end

    // Free-running blink divider, shared by all pins so they stay in phase
    blink_tick = (s_reg.blink_pre == 23'(BLINK_TICK_CYCLES - 1));
    s_next.blink_pre = blink_tick ? 23'h000000 : s_reg.blink_pre + 23'h000001;
    if (blink_tick) begin
      s_next.blink_cnt = s_reg.blink_cnt + 4'h1;
    end
    if (burst_done_in) begin
      s_next.burst_tgl = ~s_reg.burst_tgl;
    end
    if (wr_hit && reg_req_in.addr == `OFS_CFG && reg_req_in.wdata[`CFG_RESTART_BIT]) begin
      s_next.blink_pre = 23'h000000;
      s_next.blink_cnt = 4'h0;
      s_next.burst_tgl = 1'b0;
    end
    blink_a = s_reg.blink_cnt[s_reg.blink_gen_a_rate];
    blink_b = (s_reg.blink_gen_b_rate == 2'h3) ? s_reg.burst_tgl
                                              : s_reg.blink_cnt[s_reg.blink_gen_b_rate];

    // Activity pulses arrive from another clock: two stages, then edge
    s_next.act_s1 = port_activity_in;
    s_next.act_s2 = s_reg.act_s1;
    s_next.act_s3 = s_reg.act_s2;
    act_pulse     = s_reg.act_s2 & ~s_reg.act_s3;

    // Envelope stretch, counted in coarse ticks to keep counters narrow
    env_tick = (s_reg.env_pre == 18'(ENV_TICK_CYCLES - 1));
    s_next.env_pre = env_tick ? 18'h00000 : s_reg.env_pre + 18'h00001;
    for (int p = 0; p < `NUM_PORTS; p++) begin
      mod = act_module(CTRL_INDEX, 5'(p));
      if (act_pulse[mod]) begin
        // Extra tick on a fresh start so the envelope never falls short
        sum = (s_reg.env_cnt[p] == 8'h00) ? 9'(`ENV_STRETCH_TICKS + 1)
                                          : {1'b0, s_reg.env_cnt[p]} + 9'(`ENV_STRETCH_TICKS);
        s_next.env_cnt[p] = sum[8] ? 8'hFF : sum[7:0];
      end else if (env_tick && s_reg.env_cnt[p] != 8'h00) begin
        s_next.env_cnt[p] = s_reg.env_cnt[p] - 8'h01;
      end
    end

    // Output bit per pin
    s_next.pwm_cnt = s_reg.pwm_cnt + 8'h01;
    for (int i = 0; i < `NUM_PINS; i++) begin
      pc     = s_reg.pin_cfg[i];
      port   = 5'(i / 4);
      env_on = (s_reg.env_cnt[port] != 8'h00);
      case (pc.source)
        SRC_STATIC_LOW:  pat = 1'b0;
        SRC_STATIC_HIGH: pat = 1'b1;
        SRC_BLINK_A:     pat = blink_a;
        SRC_BLINK_B:     pat = blink_b;
        SRC_ACT_A:       pat = env_on & blink_a;
        SRC_ACT_B:       pat = env_on & blink_b;
        SRC_ACT_A_INV:   pat = ~env_on & blink_a;
        SRC_ACT_B_INV:   pat = ~env_on & blink_b;
        default:         pat = 1'b0;
      endcase
      gate = (pc.pwm_sel == 2'h0) ? 1'b1
                                  : (s_reg.pwm_cnt < s_reg.pwm_duty[2'(pc.pwm_sel - 2'h1)]);
      s_next.pin_out[i] = (pat & gate) ^ pc.invert;
    end

    // Input sampling: first burst only latches the external registers
    if (burst_done_in) begin
      if (s_reg.bursts_seen != 2'h0) begin
        s_next.sampled = serial_in_data_in;
      end
      if (s_reg.bursts_seen != 2'h2) begin
        s_next.bursts_seen = s_reg.bursts_seen + 2'h1;
      end
    end

    // Interrupt chain
    s_next.prev_raw = raw;
    for (int i = 0; i < `NUM_PINS; i++) begin
      trig = trigger_t'({s_reg.irq_trigger_high_bits[i], s_reg.irq_trigger_low_bits[i]});
      case (trig)
        TRIG_LEVEL:   set[i] = raw[i];
        TRIG_ANY:     set[i] = raw[i] ^ s_reg.prev_raw[i];
        TRIG_FALLING: set[i] = ~raw[i] & s_reg.prev_raw[i];
        TRIG_RISING:  set[i] = raw[i] & ~s_reg.prev_raw[i];
        default:      set[i] = 1'b0;
      endcase
    end
    // A set in the clearing cycle is kept
    s_next.irq_sticky_vector = (s_reg.irq_sticky_vector & ~clr) | set;
    s_next.irq = |(s_next.irq_sticky_vector & s_next.irq_enable_vector);

    // Signal detect forwarding
    for (int p = 0; p < `NUM_PORTS; p++) begin
      mod = act_module(CTRL_INDEX, 5'(p));
      if (CTRL_INDEX >= 2 && 5'(p) >= `CTRL2_SPLIT_PORT && !s_reg.signal_detect_high_map) begin
        mod = {2'b00, 5'(p)};
      end
      det[mod] = raw[p*4];
    end
    for (int m = 0; m < `NUM_MODULES; m++) begin
      if (s_reg.signal_detect_custom_map_on) begin
        det[m] = raw[s_reg.port_detect_map_table[m]];
      end
      s_next.port_detect[m] = parallel_detect_sel_in[m] ? parallel_detect_val_in[m]
                                                        : det[m];
    end
    for (int k = 0; k < `NUM_SERDES; k++) begin
      s_next.serdes_detect[k] = s_reg.signal_detect_custom_map_on &
                                raw[s_reg.serdes_detect_map_table[k]];
    end

    // Register reads, data in the following cycle only
    if (reg_req_in.addr == `OFS_CFG) begin
      rd_val = {28'h0000000, s_reg.blink_gen_b_rate, s_reg.blink_gen_a_rate};
    end else if (reg_req_in.addr == `OFS_SD_CFG) begin
      rd_val = {30'h00000000, s_reg.signal_detect_custom_map_on, s_reg.signal_detect_high_map};
    end else if (reg_req_in.addr == `OFS_PWM_DUTY) begin
      rd_val = {8'h00, s_reg.pwm_duty};
    end else if (bank == `BANK_POLARITY) begin
      rd_val = word_of(s_reg.input_polarity_vector, word);
    end else if (bank == `BANK_RAW) begin
      rd_val = word_of(raw, word);
    end else if (bank == `BANK_TRIG_LOW) begin
      rd_val = word_of(s_reg.irq_trigger_low_bits, word);
    end else if (bank == `BANK_TRIG_HIGH) begin
      rd_val = word_of(s_reg.irq_trigger_high_bits, word);
    end else if (bank == `BANK_STICKY) begin
      rd_val = word_of(s_reg.irq_sticky_vector, word);
    end else if (bank == `BANK_ENABLE) begin
      rd_val = word_of(s_reg.irq_enable_vector, word);
    end else if (bank == `BANK_ACTIVE) begin
      rd_val = word_of(active, word);
    end else if (bank == `BANK_INPUT) begin
      rd_val = word_of(s_reg.sampled, word);
    end else if (reg_req_in.addr[11:9] == `REGION_PIN_CFG) begin
      rd_val = {26'h0000000, s_reg.pin_cfg[idx]};
    end else if (reg_req_in.addr[11:9] == `REGION_PORT_MAP && idx < 7'(`NUM_MODULES)) begin
      rd_val = {25'h0000000, s_reg.port_detect_map_table[idx]};
    end else if (reg_req_in.addr[11:9] == `REGION_SERDES_MAP && idx < 7'(`NUM_SERDES)) begin
      rd_val = {25'h0000000, s_reg.serdes_detect_map_table[idx[4:0]]};
    end
    s_next.rdata = reg_req_in.rd ? rd_val : 32'h0000_0000;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_out         = s_reg.rdata;
  assign pin_out_data_out  = s_reg.pin_out;
  assign port_detect_out   = s_reg.port_detect;
  assign serdes_detect_out = s_reg.serdes_detect;
  assign irq_out           = s_reg.irq;

endmodule

`default_nettype wire

// *** verif/serial_pin_modes_sva.sv ***
// Port-level checker for the serial pin mode, interrupt and detect block
`timescale 1ns/100ps
`default_nettype none
`include "serial_pin_cfg.svh"
module serial_pin_modes_sva
  import serial_pin_pkg::*;
#(
  parameter int BLINK_TICK_CYCLES = 8,
  parameter int ENV_TICK_CYCLES   = 4
) (
  input wire logic                    clk_in,
  input wire logic                    rst_n_in,
  input wire reg_req_t                reg_req_in,
  input wire logic [31:0]             rdata_out,
  input wire logic                    burst_done_in,
  input wire logic [`NUM_MODULES-1:0] parallel_detect_sel_in,
  input wire logic [`NUM_MODULES-1:0] parallel_detect_val_in,
  input wire logic [`NUM_PINS-1:0]    pin_out_data_out,
  input wire logic [`NUM_MODULES-1:0] port_detect_out,
  input wire logic                    irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Pin config write, static source, no PWM
  sequence static_wr;
    reg_req_in.wr && reg_req_in.addr[11:9] == 3'h1 && reg_req_in.wdata[4:1] == 4'h0;
  endsequence
  // Two quiet cycles: nothing can clear or disable an interrupt
  sequence no_write;
    !reg_req_in.wr ##1 !reg_req_in.wr;
  endsequence

  a_rdata_idle: assert property (!$past(reg_req_in.rd) |-> rdata_out == 32'h0)
    else $error("read data without a read");
  a_restart_reads_zero: assert property (
    reg_req_in.rd && reg_req_in.addr == 12'h000 |=> rdata_out[31:4] == 28'h0)
    else $error("restart control read back nonzero");
  // Config lands at the write edge, the pin register one edge later
  a_static_level: assert property (static_wr ##0 !reg_req_in.wdata[5] |=> ##1
    pin_out_data_out[$past(reg_req_in.addr[8:2], 2)] == $past(reg_req_in.wdata[0], 2))
    else $error("static pin level wrong");
  a_static_invert: assert property (static_wr ##0 reg_req_in.wdata[5] |=> ##1
    pin_out_data_out[$past(reg_req_in.addr[8:2], 2)] != $past(reg_req_in.wdata[0], 2))
    else $error("inverted static pin level wrong");
  a_irq_rise_cause: assert property ($rose(irq_out) |->
    $past(reg_req_in.wr) || $past(reg_req_in.wr, 2) ||
    $past(burst_done_in, 2) || $past(burst_done_in, 3))
    else $error("interrupt rose without input update or write");
  a_irq_fall_cause: assert property ($fell(irq_out) |->
    $past(reg_req_in.wr) || $past(reg_req_in.wr, 2))
    else $error("interrupt fell without software action");
  a_irq_holds: assert property (no_write ##0 irq_out |=> irq_out)
    else $error("interrupt dropped on its own");
  a_parallel_wins: assert property (
    (port_detect_out & $past(parallel_detect_sel_in)) ==
    ($past(parallel_detect_val_in) & $past(parallel_detect_sel_in)))
    else $error("parallel detect not forwarded");
endmodule

bind serial_pin_modes serial_pin_modes_sva #(
  .BLINK_TICK_CYCLES(BLINK_TICK_CYCLES),
  .ENV_TICK_CYCLES  (ENV_TICK_CYCLES)
) u_sva (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(reg_req_in), .rdata_out(rdata_out),
  .burst_done_in(burst_done_in), .parallel_detect_sel_in(parallel_detect_sel_in),
  .parallel_detect_val_in(parallel_detect_val_in), .pin_out_data_out(pin_out_data_out),
  .port_detect_out(port_detect_out), .irq_out(irq_out)
);
`default_nettype wire

// *** verif/serial_chain_model.sv ***
// Model of the external shift chain and of the port modules' activity
`timescale 1ns/100ps
`default_nettype none
`include "serial_pin_cfg.svh"
module serial_chain_model (
  input  wire logic                    clk_in,
  input  wire logic                    link_clk_in,
  input  wire logic                    shift_go_in,
  input  wire logic [`NUM_PINS-1:0]    pins_in,
  input  wire logic [6:0]              act_idx_in,
  input  wire logic                    act_go_in,
  output logic                         burst_done_out,
  output logic [`NUM_PINS-1:0]         data_out,
  output logic [`NUM_MODULES-1:0]      activity_out
);
  logic [`NUM_PINS-1:0] latched_reg = '0;
  logic [3:0]           shift_cnt   = 4'h0;
  initial begin
    burst_done_out = 1'b0;
    data_out = '0;
    activity_out = '0;
  end
  always @(posedge clk_in) begin
    burst_done_out <= 1'b0;
    // Data is meaningless between bursts, so keep it moving
    data_out <= ~data_out;
    if (shift_go_in) begin
      shift_cnt <= 4'hC;
    end else if (shift_cnt != 4'h0) begin
      shift_cnt <= shift_cnt - 4'h1;
    end
    if (shift_cnt == 4'h1) begin
      burst_done_out <= 1'b1;
      data_out <= latched_reg;
      latched_reg <= pins_in;
    end
  end
  // Activity comes from another clock domain, high for whole link cycles
  always @(posedge link_clk_in) begin
    activity_out <= act_go_in ? (`NUM_MODULES'(1) << act_idx_in) : '0;
  end
endmodule
`default_nettype wire

// *** verif/test_serial_pin_modes.sv ***
// Self-checking bench for the serial pin mode, interrupt and detect block
`timescale 1ns/100ps
`default_nettype none
`include "serial_pin_cfg.svh"
module test_serial_pin_modes
  import serial_pin_pkg::*;
;
  localparam int BT  = 8;
  localparam int ET  = 4;
  localparam int ENV = `ENV_STRETCH_TICKS * ET;
  logic                    clk_in = 1'b0, rst_n_in = 1'b0, link_clk = 1'b0;
  reg_req_t                req = '0;
  logic [31:0]             rdata;
  logic                    bdone, irq, go = 1'b0, act_go = 1'b0;
  logic [6:0]              act_idx = 7'h0;
  logic [`NUM_PINS-1:0]    sdata, pin_out, pins = '0;
  logic [`NUM_MODULES-1:0] act, pdet, psel = '0, pval = '0;
  logic [`NUM_SERDES-1:0]  sdet;
  int                      n_mismatch = 0, checks = 0;

  always #2 clk_in = ~clk_in;
  initial #1.3 forever #16 link_clk = ~link_clk;

  serial_pin_modes #(.CTRL_INDEX(2), .BLINK_TICK_CYCLES(BT), .ENV_TICK_CYCLES(ET))
    u_serial_pin_modes (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(req),
    .rdata_out(rdata), .burst_done_in(bdone), .serial_in_data_in(sdata),
    .port_activity_in(act), .parallel_detect_sel_in(psel), .parallel_detect_val_in(pval),
    .pin_out_data_out(pin_out), .port_detect_out(pdet), .serdes_detect_out(sdet),
    .irq_out(irq));
  serial_chain_model u_serial_chain_model (.clk_in(clk_in), .link_clk_in(link_clk),
    .shift_go_in(go), .pins_in(pins), .act_idx_in(act_idx), .act_go_in(act_go),
    .burst_done_out(bdone), .data_out(sdata), .activity_out(act));

  task automatic conclude;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ran_out;
    n_mismatch++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    conclude();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    req.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic burst(input logic [`NUM_PINS-1:0] d);
    int i;
    @(posedge clk_in);
    pins <= d;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    for (i = 0; i < 20 && bdone !== 1'b1; i++) begin @(posedge clk_in); #1; end
    if (i == 20) ran_out();
  endtask
  // Counts cycles until the pin changes level
  task automatic wait_edge(input int b, input int lim, output int n);
    logic v;
    v = pin_out[b];
    for (n = 0; n < lim && pin_out[b] === v; n++) begin @(posedge clk_in); #1; end
    if (n == lim) ran_out();
  endtask
  // Activity held long enough to span two link clock edges
  task automatic pulse(input logic [6:0] idx);
    @(posedge clk_in);
    act_idx <= idx;
    act_go <= 1'b1;
    repeat (16) @(posedge clk_in);
    act_go <= 1'b0;
  endtask

  initial begin
    int n, m;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'hFFC, 32'h0);
    chk(irq, 1'b0);
    wr(12'h214, 32'h01);
    wr(12'h218, 32'h20);
    wr(12'h21C, 32'h21);
    @(posedge clk_in);
    #1 chk(pin_out[7:5], 3'h3);
    wr(12'h008, 32'h80);
    wr(12'h214, 32'h09);
    @(posedge clk_in);
    m = 0;
    repeat (256) begin @(posedge clk_in); #1 m += pin_out[5]; end
    chk(m, 128);
    wr(12'h220, 32'h2);
    wr(12'h228, 32'h2);
    wr(12'h224, 32'h3);
    for (int g = 0; g < 2; g++) begin
      for (int c = 0; c < 4; c++) begin
        wr(12'h000, 32'(c << (2 * g)) | 32'h10);
        repeat (3) @(posedge clk_in);
        #1 chk(pin_out[8 + g], 1'b0);
        if (g == 1 && c == 3) begin
          burst('0);
          repeat (2) @(posedge clk_in);
          #1 chk(pin_out[9], 1'b1);
        end else begin
          wait_edge(8 + g, 2000, n);
          wait_edge(8 + g, 2000, n);
          chk(n, BT << c);
          if (g == 0) chk(pin_out[10], pin_out[8]);
        end
      end
    end
    wr(12'h230, 32'h5);
    wr(12'h234, 32'h7);
    wr(12'h240, 32'h5);
    @(posedge clk_in);
    #1 chk(pin_out[16:12], 5'h02);
    pulse(7'h3);
    #1 chk(pin_out[16:12], 5'h01);
    wait_edge(12, 1000, n);
    chk(n >= ENV - 20 && n <= ENV + 8, 1'b1);
    pulse(7'h3);
    repeat (200) @(posedge clk_in);
    pulse(7'h3);
    wait_edge(12, 2000, n);
    chk(n > ENV + 100, 1'b1);
    wr(12'h034, 32'hA);
    wr(12'h044, 32'hC);
    wr(12'h064, 32'h8);
    burst(128'hF << 32);
    rd(12'h054, 32'h0);
    burst(128'hF << 32);
    repeat (3) @(posedge clk_in);
    rd(12'h084, 32'hF);
    rd(12'h054, 32'hB);
    rd(12'h074, 32'h8);
    chk(irq, 1'b1);
    wr(12'h054, 32'h0);
    rd(12'h054, 32'hB);
    wr(12'h064, 32'h0);
    rd(12'h074, 32'h0);
    chk(irq, 1'b0);
    wr(12'h054, 32'hF);
    rd(12'h054, 32'h1);
    burst('0);
    burst('0);
    repeat (3) @(posedge clk_in);
    rd(12'h054, 32'h7);
    rd(12'h024, 32'h0);
    wr(12'h014, 32'hF);
    rd(12'h024, 32'hF);
    burst(128'h1 << 4);
    burst(128'h1 << 4);
    repeat (3) @(posedge clk_in);
    #1 chk(pdet[1:0], 2'h2);
    chk(sdet, 32'h0);
    @(posedge clk_in);
    psel[1] <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1 chk(pdet[1], 1'b0);
    @(posedge clk_in);
    psel[1] <= 1'b0;
    wr(12'h010, 32'h10);
    repeat (2) @(posedge clk_in);
    #1 chk(pdet[1], 1'b0);
    wr(12'h018, 32'h1);
    repeat (2) @(posedge clk_in);
    #1 chk({pdet[48], pdet[16]}, 2'h1);
    wr(12'h004, 32'h1);
    repeat (2) @(posedge clk_in);
    #1 chk({pdet[48], pdet[16]}, 2'h2);
    wr(12'h414, 32'h20);
    wr(12'h608, 32'h21);
    wr(12'h004, 32'h2);
    repeat (2) @(posedge clk_in);
    #1 chk({pdet[5], sdet[2:0]}, 4'hC);
    conclude();
  end
endmodule
`default_nettype wire
